// ==== logic/tcp_pkg.sv ====
package tcp_pkg;
  // Printed offsets are register indices; byte address is four times each
  localparam logic [15:0] TCP_IDX_PIN_CONF_LOW = 16'h000E;
  localparam logic [15:0] TCP_IDX_PIN_CONF_MID = 16'h000F;
  localparam logic [15:0] TCP_IDX_TEMP_CMP_CTRL = 16'h032D;
  localparam logic [15:0] TCP_IDX_PIN_CONF_HIGH = 16'h0400;
  localparam logic [15:0] TCP_IDX_CURRENT_UPPER = 16'h0401;
  localparam logic [15:0] TCP_IDX_CMP_STATUS = 16'h0402;
  localparam int TCP_ADDR_SHIFT = 2;

  localparam logic [7:0] TCP_RESET_PIN_CONF_LOW = 8'h00;
  localparam logic [7:0] TCP_RESET_PIN_CONF_MID = 8'h00;
  localparam logic [7:0] TCP_RESET_TEMP_CMP_CTRL = 8'h00;
  localparam logic [11:0] TCP_RESET_PIN_CONF_HIGH = 12'h000;

  // Field positions
  localparam int TCP_FAULT_IN_EN_BIT = 7;
  localparam int TCP_SERIAL_EN_BIT = 6;
  localparam int TCP_READY_EN_BIT = 6;
  localparam int TCP_MID_SPARE_BIT = 7;
  localparam int TCP_MODE_LSB = 0;
  localparam int TCP_GO_BIT = 2;
  localparam int TCP_LOCK_LSB = 3;
  localparam int TCP_THR_BIT = 6;
  localparam int TCP_PIN_FIELD_W = 3;
  localparam int TCP_PINS = 8;

  // Pin indices (pin N sits at index N-1)
  localparam int TCP_PIN_READY = 0;
  localparam int TCP_PIN_SEL = 3;
  localparam int TCP_PIN_SDI = 4;
  localparam int TCP_PIN_SDO = 5;
  localparam int TCP_PIN_SCLK = 6;
  localparam int TCP_PIN_FAULT = 7;

  localparam logic [2:0] TCP_LAST_CHANNEL = 3'h7;
  localparam logic [3:0] TCP_MAX_ACTIVE = 4'h8;

  typedef enum logic [1:0] {
    TCP_RUN_IDLE = 2'b00,
    TCP_RUN_ROUND = 2'b01,
    TCP_RUN_BIST = 2'b10,
    TCP_RUN_LOCK = 2'b11
  } tcp_run_mode_t;

  typedef enum logic [2:0] {
    TCP_PIN_HIZ = 3'b000,
    TCP_PIN_ADC_CMP = 3'b001,
    TCP_PIN_ADC = 3'b010,
    TCP_PIN_DIN = 3'b011,
    TCP_PIN_HIGH = 3'b100,
    TCP_PIN_LOW = 3'b101,
    TCP_PIN_ADC_PU = 3'b110,
    TCP_PIN_ADC_PD = 3'b111
  } tcp_pin_mode_t;

  localparam logic [1:0] TCP_HTRANS_NONSEQ = 2'b10;
endpackage

// ==== logic/tcp_top.sv ====
`timescale 1ns/1ns
// Operation
// R1: Locked mode uses the captured threshold bit: 0 normal, 1 balancing.
// R2: The 3-bit channel select picks pin 1 (code 0) to pin 8 (code 7).
// R3: Software writes a new start after changing channel or mode to apply them.
// R4: A start write captures the setup, starts the comparators and reads 0.
// R5: Captured mode: 00 idle, 01 round robin, 10 self-test, 11 locked.
// R6: Round robin visits only the channels counted by the active count.
// R7: Fault-input enable makes pin 8 an active-low fault input over its mode.
// R8: Serial enable hands pins 4 to 7 to the serial controller.
// R9: With serial enable set, pin 4 drives the peripheral select line.
// R10: Mode codes 0-7: high-Z, ADC+cmp, ADC, input, high, low, ADC+PU, ADC+PD.
// R11: Ready enable drives pin 1, which falls when a current conversion ends.
// R12: A read of the current upper result returns the pin 1 strobe high.
// R13: With serial enable set, pin 5 is serial data in and pin 6 data out.
// R14: With serial enable set, pin 7 is the serial clock output.
// R15: Overridden mode fields stay stored and apply again once released.
module tcp_top
  import tcp_pkg::*;
(
  input wire logic CLK, // 250 MHz clock
  input wire logic RESET, // Async reset, active high
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB byte address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size, word only
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic [31:0] HRDATA, // AHB read data
  output logic HREADYOUT, // AHB slave ready
  output logic HRESP, // AHB response, always OKAY
  input wire logic [7:0] PIN_IN, // Pin input levels
  output logic [7:0] PIN_OUT, // Pin output levels
  output logic [7:0] PIN_OE, // Pin output enables, high drives
  output logic [7:0] PIN_ADC_EN, // Pin routed to ADC
  output logic [7:0] PIN_CMP_EN, // Pin routed to temperature compare
  output logic [7:0] PIN_PULLUP, // Weak pull-up on
  output logic [7:0] PIN_PULLDOWN, // Weak pull-down on
  output logic [7:0] PIN_DIN, // Captured digital input levels
  input wire logic SERIAL_SEL, // Serial controller select level
  input wire logic SERIAL_SDO, // Serial controller data out
  input wire logic SERIAL_SCLK, // Serial controller clock
  output logic SERIAL_SDI, // Serial controller data in
  output logic SERIAL_EN, // Serial controller enabled
  output logic FAULT_ASSERT, // Request to assert fault output pin
  input wire logic CONV_DONE, // Current conversion complete pulse
  input wire logic [7:0] CURRENT_UPPER, // Current result upper byte
  input wire logic [3:0] ACTIVE_COUNT, // Number of active channels
  input wire logic CMP_STEP, // Comparator finished one channel
  output logic CMP_RUN, // Comparators running
  output logic [1:0] CMP_MODE, // Captured run mode
  output logic [2:0] CMP_CHANNEL, // Channel feeding comparators
  output logic CMP_BAL_THR // Balancing threshold selected
);

  logic [7:0] pin_config_low_and_overrides;
  logic [7:0] pin_config_mid_and_ready_strobe;
  logic [7:0] temp_comparator_control;
  logic [11:0] pin_config_high;
  logic [7:0] next_low;
  logic [7:0] next_mid;
  logic [7:0] next_ctrl;
  logic [11:0] next_high;
  logic wr_pend;
  logic [15:0] wr_idx;
  logic addr_ok;
  logic [15:0] addr_idx;
  logic wr_hit;
  logic start;
  logic ready_strobe;
  logic rearm;
  tcp_run_mode_t run_mode;
  logic [2:0] lock_ch;
  logic [3:0] active_lim;
  logic [2:0] next_channel;
  logic [2:0] pin_mode [TCP_PINS];
  logic [TCP_PINS-1:0] nx_oe;
  logic [TCP_PINS-1:0] nx_out;
  logic [TCP_PINS-1:0] nx_adc;
  logic [TCP_PINS-1:0] nx_cmp;
  logic [TCP_PINS-1:0] nx_pu;
  logic [TCP_PINS-1:0] nx_pd;
  logic [31:0] next_rdata;

  function automatic logic [15:0] word_index(input logic [31:0] a);
    word_index = a[TCP_ADDR_SHIFT +: 16];
  endfunction

  // {oe, out, adc, cmp, pull-up, pull-down}
  function automatic logic [5:0] decode_pin(input logic [2:0] m);
    case (tcp_pin_mode_t'(m))
      TCP_PIN_HIZ: decode_pin = 6'h00;
      TCP_PIN_ADC_CMP: decode_pin = 6'h0C;
      TCP_PIN_ADC: decode_pin = 6'h08;
      TCP_PIN_DIN: decode_pin = 6'h00;
      TCP_PIN_HIGH: decode_pin = 6'h30;
      TCP_PIN_LOW: decode_pin = 6'h20;
      TCP_PIN_ADC_PU: decode_pin = 6'h0A;
      default: decode_pin = 6'h09;
    endcase
  endfunction

  // Bus address phase
  assign addr_ok = HSEL && HREADY && (HTRANS == TCP_HTRANS_NONSEQ);
  assign addr_idx = word_index(HADDR);
  assign wr_hit = wr_pend;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wr_pend <= 1'b0;
      wr_idx <= 16'h0000;
    end else begin
      wr_pend <= addr_ok && HWRITE;
      wr_idx <= addr_idx;
    end
  end

  // Zero wait states; every access is answered OKAY
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Stored fields keep their value under override [R15]
  always_comb begin
    next_low = pin_config_low_and_overrides;
    next_mid = pin_config_mid_and_ready_strobe;
    next_ctrl = temp_comparator_control;
    next_high = pin_config_high;
    start = 1'b0;
    if (wr_hit) begin
      if (wr_idx == TCP_IDX_PIN_CONF_LOW) begin
        next_low = HWDATA[7:0];
      end else if (wr_idx == TCP_IDX_PIN_CONF_MID) begin
        next_mid = HWDATA[7:0];
      end else if (wr_idx == TCP_IDX_TEMP_CMP_CTRL) begin
        next_ctrl = HWDATA[7:0];
        next_ctrl[TCP_GO_BIT] = 1'b0; // [R4]
        next_ctrl[7] = 1'b0;
        start = HWDATA[TCP_GO_BIT]; // [R4]
      end else if (wr_idx == TCP_IDX_PIN_CONF_HIGH) begin
        next_high = HWDATA[11:0];
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pin_config_low_and_overrides <= TCP_RESET_PIN_CONF_LOW;
      pin_config_mid_and_ready_strobe <= TCP_RESET_PIN_CONF_MID;
      temp_comparator_control <= TCP_RESET_TEMP_CMP_CTRL;
      pin_config_high <= TCP_RESET_PIN_CONF_HIGH;
    end else begin
      pin_config_low_and_overrides <= next_low;
      pin_config_mid_and_ready_strobe <= next_mid;
      temp_comparator_control <= next_ctrl;
      pin_config_high <= next_high;
    end
  end

  // Read mux uses next values so a read right after a write sees it
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_idx == TCP_IDX_PIN_CONF_LOW) begin
      next_rdata[7:0] = next_low;
    end else if (addr_idx == TCP_IDX_PIN_CONF_MID) begin
      next_rdata[7:0] = next_mid;
    end else if (addr_idx == TCP_IDX_TEMP_CMP_CTRL) begin
      next_rdata[7:0] = next_ctrl;
    end else if (addr_idx == TCP_IDX_PIN_CONF_HIGH) begin
      next_rdata[11:0] = next_high;
    end else if (addr_idx == TCP_IDX_CURRENT_UPPER) begin
      next_rdata[7:0] = CURRENT_UPPER;
    end else if (addr_idx == TCP_IDX_CMP_STATUS) begin
      next_rdata[7:0] = {ready_strobe, CMP_BAL_THR, CMP_CHANNEL, CMP_RUN,
                         CMP_MODE};
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  assign rearm = addr_ok && !HWRITE && (addr_idx == TCP_IDX_CURRENT_UPPER);

  // A completion in the same cycle as the rearming read wins
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ready_strobe <= 1'b1;
    end else if (CONV_DONE) begin
      ready_strobe <= 1'b0; // [R11]
    end else if (rearm) begin
      ready_strobe <= 1'b1; // [R12]
    end
  end

  // Comparator sequencing; settings act only at start [R3]
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      run_mode <= TCP_RUN_IDLE;
      lock_ch <= 3'h0;
      CMP_BAL_THR <= 1'b0;
    end else if (start) begin
      run_mode <= tcp_run_mode_t'(HWDATA[TCP_MODE_LSB +: 2]); // [R4]
      lock_ch <= HWDATA[TCP_LOCK_LSB +: 3]; // [R4]
      CMP_BAL_THR <= HWDATA[TCP_THR_BIT]; // [R1]
    end
  end

  always_comb begin
    active_lim = ACTIVE_COUNT;
    if (ACTIVE_COUNT == 4'h0) begin
      active_lim = 4'h1;
    end else if (ACTIVE_COUNT > TCP_MAX_ACTIVE) begin
      active_lim = TCP_MAX_ACTIVE;
    end
  end

  always_comb begin
    next_channel = CMP_CHANNEL;
    case (run_mode)
      TCP_RUN_IDLE: next_channel = CMP_CHANNEL;
      TCP_RUN_ROUND: begin
        if (CMP_STEP) begin
          if ({1'b0, CMP_CHANNEL} + 4'h1 >= active_lim) begin
            next_channel = 3'h0; // [R6]
          end else begin
            next_channel = CMP_CHANNEL + 3'h1; // [R6]
          end
        end
      end
      TCP_RUN_BIST: begin
        if (CMP_STEP) begin
          next_channel = CMP_CHANNEL + 3'h1;
        end
      end
      default: next_channel = lock_ch; // [R2]
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CMP_RUN <= 1'b0;
      CMP_MODE <= 2'b00;
      CMP_CHANNEL <= 3'h0;
    end else if (start) begin
      CMP_RUN <= (HWDATA[TCP_MODE_LSB +: 2] != TCP_RUN_IDLE); // [R5]
      CMP_MODE <= HWDATA[TCP_MODE_LSB +: 2]; // [R5]
      if (HWDATA[TCP_MODE_LSB +: 2] == TCP_RUN_LOCK) begin
        CMP_CHANNEL <= HWDATA[TCP_LOCK_LSB +: 3]; // [R2]
      end else begin
        CMP_CHANNEL <= 3'h0;
      end
    end else begin
      CMP_RUN <= (run_mode != TCP_RUN_IDLE);
      CMP_MODE <= run_mode;
      CMP_CHANNEL <= next_channel;
    end
  end

  // Pin mode fields gathered from their registers
  assign pin_mode[0] = pin_config_low_and_overrides[0 +: TCP_PIN_FIELD_W];
  assign pin_mode[1] = pin_config_low_and_overrides[3 +: TCP_PIN_FIELD_W];
  assign pin_mode[2] = pin_config_mid_and_ready_strobe[0 +: TCP_PIN_FIELD_W];
  assign pin_mode[3] = pin_config_mid_and_ready_strobe[3 +: TCP_PIN_FIELD_W];

  generate
    for (genvar h = 0; h < 4; h++) begin : g_high
      assign pin_mode[4 + h] = pin_config_high[h*TCP_PIN_FIELD_W +:
                                               TCP_PIN_FIELD_W];
    end
  endgenerate

  logic serial_on;
  logic fault_on;
  logic ready_on;
  assign serial_on = pin_config_low_and_overrides[TCP_SERIAL_EN_BIT];
  assign fault_on = pin_config_low_and_overrides[TCP_FAULT_IN_EN_BIT];
  assign ready_on = pin_config_mid_and_ready_strobe[TCP_READY_EN_BIT];

  generate
    for (genvar p = 0; p < TCP_PINS; p++) begin : g_pin
      logic [5:0] dec;
      logic ovr;
      logic ovr_oe;
      logic ovr_out;
      assign dec = decode_pin(pin_mode[p]); // [R10]
      always_comb begin
        ovr = 1'b0;
        ovr_oe = 1'b0;
        ovr_out = 1'b0;
        if (p == TCP_PIN_READY && ready_on) begin
          ovr = 1'b1; // [R11]
          ovr_oe = 1'b1;
          ovr_out = ready_strobe;
        end else if (p == TCP_PIN_SEL && serial_on) begin
          ovr = 1'b1; // [R8] [R9]
          ovr_oe = 1'b1;
          ovr_out = SERIAL_SEL;
        end else if (p == TCP_PIN_SDI && serial_on) begin
          ovr = 1'b1; // [R8] [R13]
        end else if (p == TCP_PIN_SDO && serial_on) begin
          ovr = 1'b1; // [R8] [R13]
          ovr_oe = 1'b1;
          ovr_out = SERIAL_SDO;
        end else if (p == TCP_PIN_SCLK && serial_on) begin
          ovr = 1'b1; // [R8] [R14]
          ovr_oe = 1'b1;
          ovr_out = SERIAL_SCLK;
        end else if (p == TCP_PIN_FAULT && fault_on) begin
          ovr = 1'b1; // [R7]
        end
      end
      assign nx_oe[p] = ovr ? ovr_oe : dec[5];
      assign nx_out[p] = ovr ? ovr_out : dec[4];
      assign nx_adc[p] = ovr ? 1'b0 : dec[3];
      assign nx_cmp[p] = ovr ? 1'b0 : dec[2];
      assign nx_pu[p] = ovr ? 1'b0 : dec[1];
      assign nx_pd[p] = ovr ? 1'b0 : dec[0];
    end
  endgenerate

  // Pin controls are registered, adding one cycle of latency
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PIN_OE <= 8'h00;
      PIN_OUT <= 8'h00;
      PIN_ADC_EN <= 8'h00;
      PIN_CMP_EN <= 8'h00;
      PIN_PULLUP <= 8'h00;
      PIN_PULLDOWN <= 8'h00;
      PIN_DIN <= 8'h00;
    end else begin
      PIN_OE <= nx_oe;
      PIN_OUT <= nx_out;
      PIN_ADC_EN <= nx_adc;
      PIN_CMP_EN <= nx_cmp;
      PIN_PULLUP <= nx_pu;
      PIN_PULLDOWN <= nx_pd;
      PIN_DIN <= PIN_IN;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SERIAL_EN <= 1'b0;
      SERIAL_SDI <= 1'b0;
      FAULT_ASSERT <= 1'b0;
    end else begin
      SERIAL_EN <= serial_on; // [R8]
      SERIAL_SDI <= serial_on && PIN_IN[TCP_PIN_SDI]; // [R13]
      FAULT_ASSERT <= fault_on && !PIN_IN[TCP_PIN_FAULT]; // [R7]
    end
  end

endmodule // tcp_top

// ==== verification/tcp_top_chk.sv ====
`timescale 1ns/1ns
module tcp_chk
  import tcp_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RESET, // Async reset
  input wire logic HSEL, // Select
  input wire logic [31:0] HADDR, // Address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  input wire logic HREADYOUT, // Slave ready
  input wire logic HRESP, // Response
  input wire logic [7:0] PIN_IN, // Pin levels
  input wire logic [7:0] PIN_OUT, // Pin drive
  input wire logic [7:0] PIN_OE, // Pin enables
  input wire logic SERIAL_SEL, // Select from controller
  input wire logic SERIAL_SDO, // Data from controller
  input wire logic SERIAL_SCLK, // Clock from controller
  input wire logic SERIAL_EN, // Serial enabled
  input wire logic FAULT_ASSERT, // Fault request
  input wire logic CMP_RUN, // Running
  input wire logic [1:0] CMP_MODE, // Mode
  input wire logic [2:0] CMP_CHANNEL, // Channel
  input wire logic CMP_BAL_THR // Threshold select
);
  logic ctrl_wr;
  logic start;
  // Tracks the address phase so a start is seen in its data phase
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_wr <= 1'b0;
    end else if (HREADY) begin
      ctrl_wr <= HSEL && HTRANS == TCP_HTRANS_NONSEQ && HWRITE &&
                 HADDR == {14'h0000, TCP_IDX_TEMP_CMP_CTRL, 2'b00};
    end
  end
  assign start = ctrl_wr && HWDATA[TCP_GO_BIT];
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_bus_zero_wait: assert property ($past(!RESET) |-> HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  a_start_mode: assert property (start |=>
    CMP_MODE == $past(HWDATA[1:0]) &&
    CMP_RUN == ($past(HWDATA[1:0]) != 2'b00)) else $error("start mode");
  a_lock_capture: assert property (start && HWDATA[1:0] == 2'b11
    |=> CMP_CHANNEL == $past(HWDATA[5:3]) &&
    CMP_BAL_THR == $past(HWDATA[6])) else $error("lock capture");
  a_round_first: assert property (start && HWDATA[1:0] == 2'b01 |=>
    CMP_CHANNEL == 3'h0) else $error("round robin start");
  a_lock_held: assert property (!start && CMP_MODE == 2'b11 |=>
    $stable(CMP_CHANNEL) && $stable(CMP_BAL_THR)) else $error("lock moved");
  a_sel_route: assert property (SERIAL_EN && $past(SERIAL_EN) |->
    PIN_OE[3] && PIN_OUT[3] == $past(SERIAL_SEL)) else $error("select pin");
  a_data_route: assert property (SERIAL_EN && $past(SERIAL_EN) |->
    PIN_OE[5] && !PIN_OE[4] && PIN_OUT[5] == $past(SERIAL_SDO))
    else $error("data pins");
  a_sclk_route: assert property (SERIAL_EN && $past(SERIAL_EN) |->
    PIN_OE[6] && PIN_OUT[6] == $past(SERIAL_SCLK)) else $error("clock pin");
  a_fault_input: assert property (FAULT_ASSERT |->
    !$past(PIN_IN[7]) && !PIN_OE[7]) else $error("fault input");
endmodule // tcp_chk

bind tcp_top tcp_chk tcp_chk_i (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .SERIAL_SEL(SERIAL_SEL),
  .SERIAL_SDO(SERIAL_SDO), .SERIAL_SCLK(SERIAL_SCLK), .SERIAL_EN(SERIAL_EN),
  .FAULT_ASSERT(FAULT_ASSERT), .CMP_RUN(CMP_RUN), .CMP_MODE(CMP_MODE),
  .CMP_CHANNEL(CMP_CHANNEL), .CMP_BAL_THR(CMP_BAL_THR));

// ==== verification/temp_compare_and_pin_config_tb.sv ====
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module temp_compare_and_pin_config_tb;
  import tcp_pkg::*;
  logic CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, HREADY;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0] HTRANS = 2'b00, CMP_MODE;
  logic [2:0] HSIZE = 3'b010, CMP_CHANNEL;
  logic [7:0] PIN_IN = 8'h80, CURRENT_UPPER = 8'h5A;
  logic SERIAL_SEL = 1'b0, SERIAL_SDO = 1'b0, SERIAL_SCLK = 1'b1;
  logic CONV_DONE = 1'b0, CMP_STEP = 1'b0;
  logic [3:0] ACTIVE_COUNT = 4'h3;
  logic HREADYOUT, HRESP, SERIAL_SDI, SERIAL_EN, FAULT_ASSERT;
  logic CMP_RUN, CMP_BAL_THR;
  logic [7:0] PIN_OUT, PIN_OE, PIN_ADC_EN, PIN_CMP_EN, PIN_PULLUP;
  logic [7:0] PIN_PULLDOWN, PIN_DIN;
  logic [31:0] r;
  logic [2:0] m;
  int n_errors = 0, n_tests = 0;
  // Per mode: {drive enable, level, ADC, compare, pull-up, pull-down}
  logic [5:0] exp_tbl [8] = '{6'h00, 6'h0C, 6'h08, 6'h00,
                              6'h30, 6'h20, 6'h0A, 6'h09};
  assign HREADY = HREADYOUT;
  always #2 CLK = ~CLK;

  tcp_top tcp_top_i (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_ADC_EN(PIN_ADC_EN), .PIN_CMP_EN(PIN_CMP_EN),
    .PIN_PULLUP(PIN_PULLUP), .PIN_PULLDOWN(PIN_PULLDOWN), .PIN_DIN(PIN_DIN),
    .SERIAL_SEL(SERIAL_SEL), .SERIAL_SDO(SERIAL_SDO),
    .SERIAL_SCLK(SERIAL_SCLK), .SERIAL_SDI(SERIAL_SDI),
    .SERIAL_EN(SERIAL_EN), .FAULT_ASSERT(FAULT_ASSERT),
    .CONV_DONE(CONV_DONE), .CURRENT_UPPER(CURRENT_UPPER),
    .ACTIVE_COUNT(ACTIVE_COUNT), .CMP_STEP(CMP_STEP), .CMP_RUN(CMP_RUN),
    .CMP_MODE(CMP_MODE), .CMP_CHANNEL(CMP_CHANNEL),
    .CMP_BAL_THR(CMP_BAL_THR));

  // The master waits on ready itself; only the watchdog bounds a hang
  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [31:0] d, output logic [31:0] rd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HWRITE <= w;
    HTRANS <= TCP_HTRANS_NONSEQ;
    HADDR <= {14'h0000, idx, 2'b00};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, idx, d, dummy);
  endtask

  task automatic settle();
    repeat (2) @(posedge CLK);
    #1;
  endtask

  task automatic step();
    @(posedge CLK);
    CMP_STEP <= 1'b1;
    @(posedge CLK);
    CMP_STEP <= 1'b0;
    #1;
  endtask

  function automatic logic [47:0] spread(input logic [5:0] e);
    return {{8{e[5]}}, {8{e[4]}}, {8{e[3]}}, {8{e[2]}}, {8{e[1]}},
            {8{e[0]}}};
  endfunction

  function automatic logic [47:0] pin_ctl();
    return {PIN_OE, PIN_OUT, PIN_ADC_EN, PIN_CMP_EN, PIN_PULLUP,
            PIN_PULLDOWN};
  endfunction

  function automatic logic [6:0] cmp_state();
    return {CMP_RUN, CMP_MODE, CMP_CHANNEL, CMP_BAL_THR};
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge CLK);
    #1;
    `CHK("ready in reset", 1'b0, HREADYOUT)
    @(posedge CLK);
    RESET <= 1'b0;
    settle();
    xfer(1'b0, TCP_IDX_PIN_CONF_LOW, 32'h0, r);
    `CHK("low reset", {24'h0, TCP_RESET_PIN_CONF_LOW}, r)
    xfer(1'b0, TCP_IDX_PIN_CONF_MID, 32'h0, r);
    `CHK("mid reset", {24'h0, TCP_RESET_PIN_CONF_MID}, r)
    xfer(1'b0, TCP_IDX_TEMP_CMP_CTRL, 32'h0, r);
    `CHK("ctrl reset", {24'h0, TCP_RESET_TEMP_CMP_CTRL}, r)
    xfer(1'b0, 16'h0123, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(TCP_IDX_PIN_CONF_LOW, {26'h0, m, m});
      wr(TCP_IDX_PIN_CONF_MID, {26'h0, m, m});
      wr(TCP_IDX_PIN_CONF_HIGH, {20'h0, m, m, m, m});
      settle();
      `CHK("pin modes", spread(exp_tbl[i]), pin_ctl())
      xfer(1'b0, TCP_IDX_PIN_CONF_LOW, 32'h0, r);
      `CHK("low readback", {26'h0, m, m}, r)
    end
    PIN_IN <= 8'h10;
    wr(TCP_IDX_PIN_CONF_LOW, 32'h64);
    wr(TCP_IDX_PIN_CONF_MID, 32'h24);
    wr(TCP_IDX_PIN_CONF_HIGH, 32'h924);
    settle();
    `CHK("serial oe", 8'hEF, PIN_OE)
    `CHK("serial out", 8'hC7, PIN_OUT & 8'hEF)
    `CHK("serial in", 2'b11, {SERIAL_EN, SERIAL_SDI})
    `CHK("digital in", 8'h10, PIN_DIN)
    @(posedge CLK);
    {SERIAL_SEL, SERIAL_SDO, SERIAL_SCLK} <= 3'b110;
    PIN_IN <= 8'h00;
    settle();
    `CHK("serial follow", 8'hAF, PIN_OUT & 8'hEF)
    `CHK("serial in low", 1'b0, SERIAL_SDI)
    wr(TCP_IDX_PIN_CONF_LOW, 32'hA4);
    settle();
    `CHK("fault oe", 8'h7F, PIN_OE)
    `CHK("fault out", 8'h7F, PIN_OUT & 8'h7F)
    `CHK("fault on", 2'b10, {FAULT_ASSERT, SERIAL_EN})
    @(posedge CLK);
    PIN_IN <= 8'h80;
    settle();
    `CHK("fault off", 1'b0, FAULT_ASSERT)
    wr(TCP_IDX_PIN_CONF_MID, 32'h64);
    settle();
    `CHK("strobe idle", 2'b11, {PIN_OE[0], PIN_OUT[0]})
    @(posedge CLK);
    CONV_DONE <= 1'b1;
    @(posedge CLK);
    CONV_DONE <= 1'b0;
    settle();
    `CHK("strobe low", 2'b10, {PIN_OE[0], PIN_OUT[0]})
    xfer(1'b0, TCP_IDX_CURRENT_UPPER, 32'h0, r);
    `CHK("current upper", 32'h5A, r)
    settle();
    `CHK("strobe rearm", 1'b1, PIN_OUT[0])
    wr(TCP_IDX_TEMP_CMP_CTRL, 32'h1B);
    settle();
    `CHK("no start", 1'b0, CMP_RUN)
    xfer(1'b0, TCP_IDX_TEMP_CMP_CTRL, 32'h0, r);
    `CHK("ctrl stored", 32'h1B, r)
    wr(TCP_IDX_TEMP_CMP_CTRL, 32'h5F);
    settle();
    `CHK("lock run", 7'h77, cmp_state())
    xfer(1'b0, TCP_IDX_TEMP_CMP_CTRL, 32'h0, r);
    `CHK("start clears", 32'h5B, r)
    step();
    `CHK("lock stays", 3'h3, CMP_CHANNEL)
    wr(TCP_IDX_TEMP_CMP_CTRL, 32'h05);
    settle();
    `CHK("round start", 6'h28, {CMP_RUN, CMP_MODE, CMP_CHANNEL})
    for (int k = 1; k < 4; k++) begin
      step();
      `CHK("round channel", 3'(k % 3), CMP_CHANNEL)
    end
    wr(TCP_IDX_TEMP_CMP_CTRL, 32'h06);
    repeat (7) step();
    `CHK("self test", 6'h37, {CMP_RUN, CMP_MODE, CMP_CHANNEL})
    step();
    `CHK("self test wrap", 3'h0, CMP_CHANNEL)
    wr(TCP_IDX_TEMP_CMP_CTRL, 32'h3F);
    settle();
    `CHK("lock last", 7'h7E, cmp_state())
    wr(TCP_IDX_TEMP_CMP_CTRL, 32'h04);
    settle();
    `CHK("idle", 3'h0, {CMP_RUN, CMP_MODE})
    @(posedge CLK);
    RESET <= 1'b1;
    settle();
    `CHK("pins in reset", 17'h0, {HREADYOUT, PIN_OE, PIN_OUT})
    @(posedge CLK);
    RESET <= 1'b0;
    settle();
    xfer(1'b0, TCP_IDX_PIN_CONF_MID, 32'h0, r);
    `CHK("mid after reset", 32'h0, r)
    `CHK("pins after reset", 8'h00, PIN_OE)
    end_of_test();
  end
endmodule // temp_compare_and_pin_config_tb
